// ===== verilog/smp_regs.svh
// register offsets, fields and timing constants of the stepper profile controller
// Functional notes
// - max speed held in steps per second
// - accel and decel held in steps/s2
// - profile accel sets both; decel write overrides
// - new accel overwrites stored deceleration register
// - move before any profile sets fault
// - new profile applies at once, keeps omitted
// - ramp change mid-ramp takes effect immediately
// - motion status readable in status register
// - home search direction from contact state
// - home input sampled every millisecond
// - home transition stops and zeroes position
// - absolute move picks direction from position
// - relative move steps given count, direction
// - velocity mode runs until stop or limit
// - move or zero while moving is refused
// - one position count shared by all modes
// - soft stop ramps down at deceleration
// - hard stop ends stepping at once
// - running or stopped reported
// - speed, accel and decel profile fields all used
// - forward limit stops clockwise motion
// - reverse limit stops counterclockwise motion
`ifndef SMP_REGS_SVH
`define SMP_REGS_SVH
`define SMP_REG_MAXSPD 8'h00
`define SMP_REG_ACCEL 8'h04
`define SMP_REG_DECEL 8'h08
`define SMP_REG_TARGET 8'h0c
`define SMP_REG_CMD 8'h10
`define SMP_REG_STATUS 8'h14
`define SMP_REG_POS 8'h18
`define SMP_REG_SPEED 8'h1c
`define SMP_CMD_ABS 4'h1
`define SMP_CMD_REL 4'h2
`define SMP_CMD_VEL 4'h3
`define SMP_CMD_HOME 4'h4
`define SMP_CMD_ZERO 4'h5
`define SMP_CMD_SOFT 4'h6
`define SMP_CMD_HALT 4'h7
`define SMP_CMD_DIR_BIT 4
`define SMP_ST_RUN 0
`define SMP_ST_FAULT 1
`define SMP_ST_DIR 2
`define SMP_ST_PROF 3
`define SMP_CLK_HZ 40000000
`define SMP_TICK_MS 1
`define SMP_TICK_CYC (`SMP_CLK_HZ / 1000 * `SMP_TICK_MS)
`define SMP_PULSE_NS 1000
`define SMP_PULSE_CYC ((`SMP_PULSE_NS * 40 + 999) / 1000)
`endif

// ===== verilog/smp_pkg.sv
// types of the stepper profile controller
`default_nettype none
package smp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_HOME
  } smp_state_type;
  typedef struct packed {
    logic fwd_limit;
    logic rev_limit;
    logic home_in;
  } smp_inputs_type;
  typedef struct packed {
    smp_state_type st;
    logic [31:0] maxspd;
    logic [31:0] accel;
    logic [31:0] decel;
    logic [31:0] target;
    logic signed [31:0] pos;
    logic [31:0] remain;
    logic [31:0] speed;
    logic [31:0] acc_us;
    logic [31:0] phase;
    logic [9:0] us_cnt;
    logic [15:0] tick_cnt;
    logic [5:0] pulse_cnt;
    logic dir;
    logic velmode;
    logic stopping;
    logic prof_ok;
    logic fault;
    logic home_ref;
    logic step;
    logic [31:0] rdata;
    logic wait_n;
    logic [7:0] lim_hist;
  } smp_state_reg_type;
endpackage : smp_pkg
`default_nettype wire

// ===== verilog/smp_ctrl.sv
// stepper motion profile controller with avalon-mm register slave
`include "smp_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module smp_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire smp_pkg::smp_inputs_type pins,
  output logic step_out,
  output logic dir_out,
  output logic running
);
  smp_pkg::smp_state_reg_type s_r, s_nxt;

  // distance needed to stop from speed v at rate a: v*v/(2a)
  function automatic logic [31:0] stop_dist(input logic [31:0] v, input logic [31:0] a);
    logic [63:0] sq;
    sq = 64'(v) * 64'(v);
    if (a == 32'h0) begin
      stop_dist = 32'h0;
    end else begin
      stop_dist = 32'(sq / (64'(a) << 1));
    end
  endfunction : stop_dist

  // speed units gained in one microsecond at a ramp rate, with the carried remainder
  function automatic logic [63:0] ramp_split(input logic [31:0] acc, input logic [31:0] r);
    logic [32:0] sum;
    logic [32:0] quo;
    sum = 33'(acc) + 33'(r);
    quo = sum / 33'd1000000;
    ramp_split = {quo[31:0], 32'(sum - quo * 33'd1000000)};
  endfunction : ramp_split

  logic us_tick;
  logic ms_tick;
  logic acc_tick;
  logic dec_tick;
  logic new_move;
  logic [3:0] cmd;
  logic [31:0] rate;
  logic blocked;
  logic halting;
  logic busy;
  logic [63:0] split;

  always_comb begin
    s_nxt = s_r;
    us_tick = (s_r.us_cnt == 10'd39);
    ms_tick = (s_r.tick_cnt == 16'(`SMP_TICK_CYC - 1));
    cmd = avs_writedata[3:0];
    new_move = 1'b0;
    acc_tick = 1'b0;
    dec_tick = 1'b0;
    rate = 32'h0;
    blocked = 1'b0;
    halting = 1'b0;
    split = 64'h0;
    // a pulse still standing counts as motion, so no new move turns dir under it
    busy = (s_r.st != smp_pkg::ST_IDLE) || s_r.step;
    s_nxt.us_cnt = us_tick ? 10'd0 : s_r.us_cnt + 10'd1;
    s_nxt.tick_cnt = ms_tick ? 16'd0 : s_r.tick_cnt + 16'd1;
    // bus: one wait cycle; writes act on the answering edge, reads latch before it
    s_nxt.wait_n = (avs_read || avs_write) && !s_r.wait_n;
    if (avs_read || avs_write) begin
      if (avs_write && s_r.wait_n) begin
        if (avs_address == `SMP_REG_MAXSPD) begin
          s_nxt.maxspd = avs_writedata;
          s_nxt.prof_ok = 1'b1;
        end else if (avs_address == `SMP_REG_ACCEL) begin
          s_nxt.accel = avs_writedata;
          s_nxt.decel = avs_writedata;
          s_nxt.prof_ok = 1'b1;
        end else if (avs_address == `SMP_REG_DECEL) begin
          s_nxt.decel = avs_writedata;
        end else if (avs_address == `SMP_REG_TARGET) begin
          s_nxt.target = avs_writedata;
        end else if (avs_address == `SMP_REG_STATUS) begin
          if (avs_writedata[`SMP_ST_FAULT]) begin
            s_nxt.fault = 1'b0;
          end
        end else if (avs_address == `SMP_REG_CMD) begin
          if (cmd == `SMP_CMD_HALT) begin
            s_nxt.st = smp_pkg::ST_IDLE;
            halting = 1'b1;
            s_nxt.speed = 32'h0;
            s_nxt.stopping = 1'b0;
          end else if (cmd == `SMP_CMD_SOFT) begin
            if (s_r.st != smp_pkg::ST_IDLE) begin
              s_nxt.stopping = 1'b1;
            end
          end else if (cmd >= `SMP_CMD_ABS && cmd <= `SMP_CMD_ZERO) begin
            if (busy) begin
              s_nxt.fault = 1'b1;
            end else if (!s_r.prof_ok && cmd != `SMP_CMD_ZERO) begin
              s_nxt.fault = 1'b1;
            end else begin
              new_move = 1'b1;
            end
          end
        end
      end else if (avs_read && !s_r.wait_n) begin
        if (avs_address == `SMP_REG_MAXSPD) begin
          s_nxt.rdata = s_r.maxspd;
        end else if (avs_address == `SMP_REG_ACCEL) begin
          s_nxt.rdata = s_r.accel;
        end else if (avs_address == `SMP_REG_DECEL) begin
          s_nxt.rdata = s_r.decel;
        end else if (avs_address == `SMP_REG_TARGET) begin
          s_nxt.rdata = s_r.target;
        end else if (avs_address == `SMP_REG_STATUS) begin
          s_nxt.rdata = {28'h0, s_r.prof_ok, s_r.dir, s_r.fault,
                         busy};
        end else if (avs_address == `SMP_REG_POS) begin
          s_nxt.rdata = s_r.pos;
        end else if (avs_address == `SMP_REG_SPEED) begin
          s_nxt.rdata = s_r.speed;
        end else begin
          s_nxt.rdata = 32'h0;
        end
      end
    end
    // start of a move
    if (new_move) begin
      s_nxt.stopping = 1'b0;
      s_nxt.velmode = 1'b0;
      s_nxt.speed = 32'h0;
      s_nxt.acc_us = 32'h0;
      s_nxt.phase = 32'h0;
      if (cmd == `SMP_CMD_ZERO) begin
        s_nxt.pos = 32'sh0;
      end else if (cmd == `SMP_CMD_ABS) begin
        s_nxt.dir = ($signed(s_r.target) > s_r.pos);
        s_nxt.remain = ($signed(s_r.target) > s_r.pos) ? 32'(s_r.target - s_r.pos)
                                                      : 32'(s_r.pos - s_r.target);
        s_nxt.st = (s_r.target == s_r.pos) ? smp_pkg::ST_IDLE : smp_pkg::ST_RUN;
      end else if (cmd == `SMP_CMD_REL) begin
        s_nxt.dir = avs_writedata[`SMP_CMD_DIR_BIT];
        s_nxt.remain = s_r.target;
        s_nxt.st = (s_r.target == 32'h0) ? smp_pkg::ST_IDLE : smp_pkg::ST_RUN;
      end else if (cmd == `SMP_CMD_VEL) begin
        s_nxt.dir = avs_writedata[`SMP_CMD_DIR_BIT];
        s_nxt.velmode = 1'b1;
        s_nxt.st = smp_pkg::ST_RUN;
      end else begin
        s_nxt.dir = pins.home_in;
        s_nxt.home_ref = pins.home_in;
        s_nxt.velmode = 1'b1;
        s_nxt.st = smp_pkg::ST_HOME;
      end
    end
    // motion generator
    if (s_r.st != smp_pkg::ST_IDLE && !new_move && !halting) begin
      blocked = (s_r.dir && pins.fwd_limit) || (!s_r.dir && pins.rev_limit);
      if (s_r.st == smp_pkg::ST_HOME && ms_tick && pins.home_in != s_r.home_ref) begin
        s_nxt.st = smp_pkg::ST_IDLE;
        s_nxt.pos = 32'sh0;
        s_nxt.speed = 32'h0;
      end else if (blocked) begin
        s_nxt.st = smp_pkg::ST_IDLE;
        s_nxt.speed = 32'h0;
      end else if (us_tick) begin
        // ramp: accumulate rate per microsecond, one speed unit per overflow
        if (s_r.stopping || (!s_r.velmode &&
            stop_dist(s_r.speed, s_r.decel) >= s_r.remain)) begin
          rate = s_r.decel;
          dec_tick = 1'b1;
        end else if (s_r.speed < s_r.maxspd) begin
          rate = s_r.accel;
          acc_tick = 1'b1;
        end
        if (acc_tick || dec_tick) begin
          split = ramp_split(s_r.acc_us, rate);
          s_nxt.acc_us = split[31:0];
          if (split[63:32] != 32'h0) begin
            if (acc_tick) begin
              s_nxt.speed = (33'(s_r.speed) + 33'(split[63:32]) > 33'(s_r.maxspd)) ?
                            s_r.maxspd : s_r.speed + split[63:32];
            end else if (s_r.speed > split[63:32]) begin
              s_nxt.speed = s_r.speed - split[63:32];
            end else if (s_r.stopping) begin
              s_nxt.st = smp_pkg::ST_IDLE;
              s_nxt.speed = 32'h0;
            end else begin
              s_nxt.speed = 32'd1;
            end
          end
        end
        if (s_r.speed > s_r.maxspd) begin
          s_nxt.speed = s_r.maxspd;
        end
        if (s_r.speed == 32'h0 && rate == 32'h0 && s_r.maxspd != 32'h0) begin
          s_nxt.speed = 32'd1;
        end
        // step phase accumulator in step-microseconds
        if (s_r.phase + s_r.speed >= 32'd1000000) begin
          s_nxt.phase = 32'(s_r.phase + s_r.speed - 32'd1000000);
          s_nxt.step = 1'b1;
          s_nxt.pulse_cnt = 6'(`SMP_PULSE_CYC);
          s_nxt.pos = s_r.dir ? s_r.pos + 32'sd1 : s_r.pos - 32'sd1;
          if (!s_r.velmode) begin
            s_nxt.remain = s_r.remain - 32'd1;
            if (s_r.remain == 32'd1) begin
              s_nxt.st = smp_pkg::ST_IDLE;
              s_nxt.speed = 32'h0;
            end
          end
        end else begin
          s_nxt.phase = s_r.phase + s_r.speed;
        end
      end
    end
    if (s_r.pulse_cnt != 6'd0) begin
      s_nxt.pulse_cnt = s_r.pulse_cnt - 6'd1;
      if (s_r.pulse_cnt == 6'd1) begin
        s_nxt.step = 1'b0;
      end
    end
    s_nxt.lim_hist = {s_r.lim_hist[6:0], blocked};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !s_r.wait_n;
  assign step_out = s_r.step;
  assign dir_out = s_r.dir;
  assign running = busy;

  a_fault_no_prof: assert property (@(posedge clk) disable iff (srst)
    (avs_write && !avs_waitrequest && avs_address == `SMP_REG_CMD &&
     avs_writedata[3:0] == `SMP_CMD_ABS && !s_r.prof_ok) |=> (s_r.fault && !running))
    else $error("move without profile not refused");
  a_busy_refuse: assert property (@(posedge clk) disable iff (srst)
    (avs_write && !avs_waitrequest && avs_address == `SMP_REG_CMD && running &&
     avs_writedata[3:0] >= `SMP_CMD_ABS &&
     avs_writedata[3:0] <= `SMP_CMD_ZERO) |=> s_r.fault)
    else $error("move while running not refused");
  a_accel_decel: assert property (@(posedge clk) disable iff (srst)
    (avs_write && !avs_waitrequest && avs_address == `SMP_REG_ACCEL) |=>
    (s_r.decel == $past(avs_writedata)))
    else $error("accel write did not copy to decel");
  sequence s_axis_idle;
    (s_r.st == smp_pkg::ST_IDLE) ##1 (s_r.st == smp_pkg::ST_IDLE);
  endsequence : s_axis_idle
  a_halt_now: assert property (@(posedge clk) disable iff (srst)
    (avs_write && !avs_waitrequest && avs_address == `SMP_REG_CMD &&
     avs_writedata[3:0] == `SMP_CMD_HALT) |=> s_axis_idle)
    else $error("halt did not stop");
  a_fwd_limit: assert property (@(posedge clk) disable iff (srst)
    (s_r.st != smp_pkg::ST_IDLE && s_r.dir && pins.fwd_limit && !new_move) |=>
    (s_r.st == smp_pkg::ST_IDLE))
    else $error("forward limit ignored");
  a_rev_limit: assert property (@(posedge clk) disable iff (srst)
    (s_r.st != smp_pkg::ST_IDLE && !s_r.dir && pins.rev_limit && !new_move) |=>
    (s_r.st == smp_pkg::ST_IDLE))
    else $error("reverse limit ignored");
  a_dir_stable: assert property (@(posedge clk) disable iff (srst)
    (step_out && $past(step_out)) |-> $stable(dir_out))
    else $error("direction moved during pulse");
  a_home_zero: assert property (@(posedge clk) disable iff (srst)
    (s_r.st == smp_pkg::ST_HOME && ms_tick && pins.home_in != s_r.home_ref && !halting)
    |=> (!running && s_r.pos == 32'sh0))
    else $error("home did not zero");
  a_pos_count: assert property (@(posedge clk) disable iff (srst)
    ($rose(step_out) && s_r.st != smp_pkg::ST_HOME) |->
    (s_r.pos == $past(s_r.pos) + (dir_out ? 32'sd1 : -32'sd1)))
    else $error("position not tracking steps");
  a_wait_once: assert property (@(posedge clk) disable iff (srst)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");
  a_pulse_width: assert property (@(posedge clk) disable iff (srst)
    $rose(step_out) |-> step_out [*8])
    else $error("step pulse too short");
endmodule : smp_ctrl
`default_nettype wire

// ===== bench/smp_drive_model.sv
// behavioural stepper drive that counts step pulses by direction
`timescale 1ns/1ps
`default_nettype none
module smp_drive_model (
  input wire logic clk,
  input wire logic step,
  input wire logic dir,
  output int pos,
  output int bad
);
  int cnt = 0;
  int err = 0;
  logic step_d = 1'b0;
  logic dir_d = 1'b0;
  assign pos = cnt;
  assign bad = err;
  always @(posedge clk) begin
    step_d <= step;
    if (step && !step_d) begin
      dir_d <= dir;
      cnt <= dir ? cnt + 1 : cnt - 1;
    end
    if (step && step_d && dir !== dir_d) begin
      err <= err + 1;
    end
  end
endmodule : smp_drive_model
`default_nettype wire

// ===== bench/test_smp_ctrl.sv
// self-checking bench for the stepper profile controller
`include "smp_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_smp_ctrl;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  smp_pkg::smp_inputs_type pins = '0;
  logic step_out;
  logic dir_out;
  logic running;
  int drv_pos;
  int drv_bad;
  int mismatches = 0;
  int check_count = 0;
  int seed = 31;
  int n;
  int base;
  logic [31:0] exp_q[$];
  string name_q[$];
  smp_ctrl i_smp_ctrl (.clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(pins),
    .step_out(step_out), .dir_out(dir_out), .running(running));
  smp_drive_model i_smp_drive_model (.clk(clk), .step(step_out), .dir(dir_out),
    .pos(drv_pos), .bad(drv_bad));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      check("waitrequest", 32'h0, 32'h1);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
    bus(1'b1, a, 32'h0);
  endtask : rd
  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    while (running !== 1'b0 && k < lim) begin
      @(negedge clk);
      k++;
    end
    check("running", 32'h0, {31'h0, running});
  endtask : wait_idle
  // read results compared as they appear on the bus
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest && exp_q.size() > 0) begin
      check(name_q.pop_front(), exp_q.pop_front(), avs_readdata);
    end
  end
  initial begin
    #(25ns * 90000);
    mismatches++;
    results();
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(`SMP_REG_STATUS, 32'h0, "status after reset");
    rd(8'hfc, 32'h0, "unmapped read");
    wr(`SMP_REG_CMD, 32'h12);
    rd(`SMP_REG_STATUS, 32'h2, "fault without profile");
    wr(`SMP_REG_STATUS, 32'h2);
    $display("test reset and refusal done");
    wr(`SMP_REG_MAXSPD, 32'h00030d40);
    wr(`SMP_REG_ACCEL, 32'hee6b2800);
    rd(`SMP_REG_DECEL, 32'hee6b2800, "decel follows accel");
    wr(`SMP_REG_DECEL, 32'h3b9aca00);
    rd(`SMP_REG_DECEL, 32'h3b9aca00, "decel alone");
    rd(`SMP_REG_ACCEL, 32'hee6b2800, "accel kept");
    wr(`SMP_REG_ACCEL, 32'hee6b2800);
    rd(`SMP_REG_DECEL, 32'hee6b2800, "decel overwritten");
    rd(`SMP_REG_MAXSPD, 32'h00030d40, "max speed");
    rd(`SMP_REG_STATUS, 32'h8, "profile loaded");
    $display("test profile done");
    n = 5 + ($unsigned($random(seed)) % 16);
    base = drv_pos;
    wr(`SMP_REG_TARGET, n);
    wr(`SMP_REG_CMD, 32'h12);
    wr(`SMP_REG_CMD, 32'h01);
    rd(`SMP_REG_STATUS, 32'hf, "refused while running");
    wr(`SMP_REG_MAXSPD, 32'h000186a0);
    rd(`SMP_REG_MAXSPD, 32'h000186a0, "profile on the fly");
    wait_idle(40000);
    wr(`SMP_REG_STATUS, 32'h2);
    rd(`SMP_REG_POS, n, "relative position");
    check("drive steps", n, drv_pos - base);
    wr(`SMP_REG_TARGET, 32'h0);
    wr(`SMP_REG_CMD, 32'h01);
    repeat (3) @(negedge clk);
    check("absolute direction", 32'h0, {31'h0, dir_out});
    wait_idle(40000);
    rd(`SMP_REG_POS, 32'h0, "absolute position");
    check("drive back at start", 32'h0, drv_pos - base);
    $display("test relative and absolute done");
    wr(`SMP_REG_CMD, 32'h13);
    repeat (2000) @(posedge clk);
    pins.fwd_limit <= 1'b1;
    wait_idle(100);
    wr(`SMP_REG_CMD, 32'h03);
    repeat (2000) @(negedge clk);
    check("ccw past forward limit", 32'h1, {31'h0, running});
    rd(`SMP_REG_SPEED, 32'h000186a0, "cruise speed");
    wr(`SMP_REG_CMD, 32'h05);
    rd(`SMP_REG_STATUS, 32'hb, "zero refused while running");
    wr(`SMP_REG_STATUS, 32'h2);
    wr(`SMP_REG_CMD, 32'h06);
    repeat (3) @(negedge clk);
    check("soft stop ramps", 32'h1, {31'h0, running});
    wait_idle(40000);
    @(posedge clk);
    pins <= '0;
    wr(`SMP_REG_CMD, 32'h03);
    repeat (2000) @(posedge clk);
    pins.rev_limit <= 1'b1;
    wait_idle(100);
    @(posedge clk);
    pins <= '0;
    wr(`SMP_REG_CMD, 32'h13);
    repeat (2000) @(posedge clk);
    wr(`SMP_REG_CMD, 32'h07);
    @(posedge clk);
    base = drv_pos;
    wait_idle(100);
    repeat (200) @(posedge clk);
    check("no step after halt", base, drv_pos);
    rd(`SMP_REG_POS, drv_pos, "position follows drive");
    wr(`SMP_REG_CMD, 32'h05);
    rd(`SMP_REG_POS, 32'h0, "zero command");
    $display("test velocity and stops done");
    wr(`SMP_REG_CMD, 32'h04);
    repeat (3) @(negedge clk);
    check("home direction", 32'h0, {31'h0, dir_out});
    repeat (4000) @(posedge clk);
    pins.home_in <= 1'b1;
    wait_idle(45000);
    rd(`SMP_REG_POS, 32'h0, "home zeroes position");
    check("direction stable in pulse", 32'h0, drv_bad);
    $display("test home done");
    results();
  end
endmodule : test_smp_ctrl
`default_nettype wire
